// >>> src/eewp_defines.svh
// Constants of the EEPROM write-gating block: timing, codes, field positions
`ifndef EEWP_DEFINES_SVH
`define EEWP_DEFINES_SVH

// Core clock rate and self-timed program time
`define EEWP_CLK_MHZ      125
`define EEWP_PROG_TIME_US 5000
`define EEWP_CNT_W        20

// Device address byte: type codes and hardware address (value arbitrary)
`define EEWP_TYPE_ARRAY   4'hA
`define EEWP_TYPE_CONFIG  4'hB
`define EEWP_HW_ADDR      3'h0

// Word address bits 7:6 that select the protection configuration register
`define EEWP_CFG_SEL      2'h3

// Configuration write data fields
`define EEWP_BIT_MARK     6
`define EEWP_BIT_CONFIRM  5
`define EEWP_BIT_LOCK     0
`define EEWP_CFG_RESET    4'h0
`define EEWP_READ_PAD     4'h0

// Lower bound of the protected range for each block-select code
`define EEWP_BOUND_QUARTER 8'hC0
`define EEWP_BOUND_HALF    8'h80
`define EEWP_BOUND_THREEQ  8'h40
`define EEWP_BOUND_FULL    8'h00

// Array organisation
`define EEWP_MEM_DEPTH    256
`define EEWP_PAGE_BYTES   8

`endif

// >>> src/eewp_pkg.sv
// Types shared by the EEPROM write-gating block
package eewp_pkg;

  // Protection configuration, packed in register bit order 3..0
  typedef struct packed {
    logic       en;
    logic [1:0] blk;
    logic       lock;
  } eewp_cfg_s;

  // Pin levels travelling together through the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
  } eewp_pins_s;

  // Byte-level protocol states
  typedef enum logic [2:0] {
    S_IDLE,
    S_DEV,
    S_WADR,
    S_WDAT,
    S_RDAT,
    S_SKIP
  } eewp_state_e;

endpackage

// >>> src/eewp_sync.sv
// Two-flop synchroniser for the link pins
`timescale 1ns/1ps
module eewp_sync
  import eewp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstN,
  // Raw pins in, synchronised copy out
  input  wire eewp_pins_s pinsIn,
  output eewp_pins_s      pinsOut
);

  eewp_pins_s meta;
  eewp_pins_s next_meta;
  eewp_pins_s next_out;

  // Next values: shift the pins through two stages
  always_comb begin
    next_meta = pinsIn;
    next_out  = meta;
  end

  // Stages reset to an idle bus (lines high, inhibit low)
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta    <= 3'h6;
      pinsOut <= 3'h6;
    end else begin
      meta    <= next_meta;
      pinsOut <= next_out;
    end
  end

endmodule

// >>> src/eewp_range_chk.sv
// Protected-range decode of the software protection configuration
`timescale 1ns/1ps
`include "eewp_defines.svh"
module eewp_range_chk
  import eewp_pkg::*;
(
  // Configuration and row address under test
  input  wire eewp_cfg_s  cfg,
  input  wire logic [7:0] addr,
  // High when the address lies in the protected range
  output logic            hit
);

  logic [7:0] bound;

  // Block select picks the lowest protected address
  always_comb begin
    case (cfg.blk)
      2'h0:    bound = `EEWP_BOUND_QUARTER;
      2'h1:    bound = `EEWP_BOUND_HALF;
      2'h2:    bound = `EEWP_BOUND_THREEQ;
      default: bound = `EEWP_BOUND_FULL;
    endcase
    hit = cfg.en && (addr >= bound);
  end

endmodule

// >>> src/eewp_top.sv
// Two-wire EEPROM core with busy polling, inhibit pin and software protection
`timescale 1ns/1ps
`include "eewp_defines.svh"
module eewp_top
  import eewp_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `EEWP_PROG_TIME_US * `EEWP_CLK_MHZ
)(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Two-wire link, data line open drain
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  // Write-inhibit pin
  input  wire logic wpIn,
  // Program cycle in progress
  output logic      progBusy
);

  logic                 rstMeta;
  logic                 rstN;
  eewp_pins_s           pinsRaw;
  eewp_pins_s           pins;
  logic                 sclD;
  logic                 sdaD;
  logic                 sclRise;
  logic                 sclFall;
  logic                 startEv;
  logic                 stopEv;
  eewp_state_e          state;
  eewp_state_e          next_state;
  logic [3:0]           bitCnt;
  logic [3:0]           next_bitCnt;
  logic                 ackPh;
  logic                 next_ackPh;
  logic                 next_sdaOe;
  logic [7:0]           shiftReg;
  logic [7:0]           next_shiftReg;
  logic [7:0]           txReg;
  logic [7:0]           next_txReg;
  logic [7:0]           ptr;
  logic [7:0]           next_ptr;
  logic                 isCfg;
  logic                 next_isCfg;
  logic                 isRd;
  logic                 next_isRd;
  logic                 cfgSel;
  logic                 next_cfgSel;
  logic [1:0]           dataCnt;
  logic [1:0]           next_dataCnt;
  logic [7:0]           cfgData;
  logic [7:0]           next_cfgData;
  logic [7:0]           pageBuf [`EEWP_PAGE_BYTES];
  logic [7:0]           next_pageBuf [`EEWP_PAGE_BYTES];
  logic [7:0]           pageMask;
  logic [7:0]           next_pageMask;
  eewp_cfg_s            cfgReg;
  eewp_cfg_s            next_cfgReg;
  logic [`EEWP_CNT_W-1:0] progCnt;
  logic [`EEWP_CNT_W-1:0] next_progCnt;
  logic                 busy;
  logic                 byteDone;
  logic                 protHit;
  logic                 wrPending;
  logic                 cfgOk;
  logic                 confirmOk;
  logic                 progStart;
  logic                 memWe;
  logic                 cfgWe;
  logic [7:0]           rdByte;
  logic [7:0]           mem [`EEWP_MEM_DEPTH];

  // Device address byte matches a type code and our hardware address
  function automatic logic addr_match(input logic [7:0] b, input logic [3:0] code);
    return (b[7:4] == code) && (b[3:1] == `EEWP_HW_ADDR);
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // Pins pass two flops before any logic looks at them
  assign pinsRaw = '{scl: sclIn, sda: sdaIn, wp: wpIn};

  eewp_sync u_sync (
    .clk     (core_clk),
    .rstN    (rstN),
    .pinsIn  (pinsRaw),
    .pinsOut (pins)
  );

  // Line edges and bus conditions from the synchronised levels
  assign sclRise  = pins.scl && !sclD;
  assign sclFall  = !pins.scl && sclD;
  assign startEv  = pins.scl && sclD && sdaD && !pins.sda;
  assign stopEv   = pins.scl && sclD && !sdaD && pins.sda;
  assign byteDone = sclFall && !ackPh && (bitCnt == 4'h8);

  // Protection check on the row that a page write targets
  eewp_range_chk u_range (
    .cfg  (cfgReg),
    .addr ({ptr[7:3], 3'h0}),
    .hit  (protHit)
  );

  // Launch decision at Stop
  assign busy      = (progCnt != '0);
  assign wrPending = (state == S_WDAT) && (dataCnt != 2'h0);
  assign cfgOk     = cfgSel && (dataCnt == 2'h1) && !cfgReg.lock
                     && cfgData[`EEWP_BIT_MARK]
                     && (cfgData[`EEWP_BIT_CONFIRM] == cfgData[`EEWP_BIT_LOCK]);
  assign confirmOk = (cfgData[`EEWP_BIT_CONFIRM] == cfgData[`EEWP_BIT_LOCK])
                     && (dataCnt == 2'h1);
  assign progStart = stopEv && wrPending && !busy
                     && (isCfg ? cfgOk : (!pins.wp && !protHit));
  assign memWe     = progStart && !isCfg;
  assign cfgWe     = progStart && isCfg;
  assign rdByte    = isCfg ? (cfgSel ? {`EEWP_READ_PAD, cfgReg} : 8'h00)
                           : mem[ptr];
  assign sdaOut    = 1'b0;
  assign progBusy  = busy;

  // Protocol next-state logic
  always_comb begin
    next_state    = state;
    next_bitCnt   = bitCnt;
    next_ackPh    = ackPh;
    next_sdaOe    = sdaOe;
    next_shiftReg = shiftReg;
    next_txReg    = txReg;
    next_ptr      = ptr;
    next_isCfg    = isCfg;
    next_isRd     = isRd;
    next_cfgSel   = cfgSel;
    next_dataCnt  = dataCnt;
    next_cfgData  = cfgData;
    next_pageBuf  = pageBuf;
    next_pageMask = pageMask;
    next_cfgReg   = cfgReg;
    if (startEv) begin
      next_state  = S_DEV;
      next_bitCnt = 4'h0;
      next_ackPh  = 1'b0;
      next_sdaOe  = 1'b0;
    end else if (stopEv) begin
      next_state = S_IDLE;
      next_ackPh = 1'b0;
      next_sdaOe = 1'b0;
      if (cfgWe) begin
        next_cfgReg = cfgData[3:0];
      end
    end else if (sclRise && !ackPh && state != S_IDLE && state != S_SKIP) begin
      next_shiftReg = {shiftReg[6:0], pins.sda};
      next_bitCnt   = bitCnt + 4'h1;
    end else if (sclRise && ackPh && state == S_RDAT) begin
      next_shiftReg = {shiftReg[6:0], pins.sda};
    end else if (byteDone && state != S_RDAT && state != S_IDLE && state != S_SKIP) begin
      next_ackPh = 1'b1;
      next_sdaOe = 1'b1;
      case (state)
        S_DEV: begin
          next_isCfg    = addr_match(shiftReg, `EEWP_TYPE_CONFIG);
          next_isRd     = shiftReg[0];
          next_sdaOe    = !busy && (addr_match(shiftReg, `EEWP_TYPE_ARRAY)
                          || addr_match(shiftReg, `EEWP_TYPE_CONFIG));
          next_dataCnt  = 2'h0;
          next_pageMask = 8'h00;
          if (!shiftReg[0]) begin
            next_cfgSel = 1'b0;
          end
        end
        S_WADR: begin
          next_ptr    = shiftReg;
          next_cfgSel = isCfg && (shiftReg[7:6] == `EEWP_CFG_SEL);
        end
        S_WDAT: begin
          next_dataCnt = (dataCnt == 2'h2) ? dataCnt : dataCnt + 2'h1;
          if (isCfg) begin
            next_cfgData = shiftReg;
          end else begin
            next_pageBuf[ptr[2:0]]  = shiftReg;
            next_pageMask[ptr[2:0]] = 1'b1;
            next_ptr[2:0]           = ptr[2:0] + 3'h1;
          end
        end
        default: begin
          next_sdaOe = 1'b0;
        end
      endcase
    end else if (sclFall && !ackPh && state == S_RDAT) begin
      if (bitCnt == 4'h8) begin
        next_sdaOe = 1'b0;
        next_ackPh = 1'b1;
      end else begin
        next_sdaOe = !txReg[3'h7 - bitCnt[2:0]];
      end
    end else if (sclFall && ackPh) begin
      next_ackPh  = 1'b0;
      next_bitCnt = 4'h0;
      next_sdaOe  = 1'b0;
      case (state)
        S_DEV: begin
          if (!sdaOe) begin
            next_state = S_SKIP;
          end else if (isRd) begin
            next_state = S_RDAT;
            next_txReg = rdByte;
            next_sdaOe = !rdByte[7];
            next_ptr   = isCfg ? ptr : ptr + 8'h01;
          end else begin
            next_state = S_WADR;
          end
        end
        S_WADR: begin
          next_state = S_WDAT;
        end
        S_RDAT: begin
          if (!shiftReg[0]) begin
            next_txReg = rdByte;
            next_sdaOe = !rdByte[7];
            next_ptr   = isCfg ? ptr : ptr + 8'h01;
          end else begin
            next_state = S_SKIP;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // Protocol registers; configuration resets to the factory state
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sclD     <= 1'b1;
      sdaD     <= 1'b1;
      state    <= S_IDLE;
      bitCnt   <= 4'h0;
      ackPh    <= 1'b0;
      sdaOe    <= 1'b0;
      shiftReg <= 8'h00;
      txReg    <= 8'h00;
      ptr      <= 8'h00;
      isCfg    <= 1'b0;
      isRd     <= 1'b0;
      cfgSel   <= 1'b0;
      dataCnt  <= 2'h0;
      cfgData  <= 8'h00;
      pageBuf  <= '{default: 8'h00};
      pageMask <= 8'h00;
      cfgReg   <= `EEWP_CFG_RESET;
    end else begin
      sclD     <= pins.scl;
      sdaD     <= pins.sda;
      state    <= next_state;
      bitCnt   <= next_bitCnt;
      ackPh    <= next_ackPh;
      sdaOe    <= next_sdaOe;
      shiftReg <= next_shiftReg;
      txReg    <= next_txReg;
      ptr      <= next_ptr;
      isCfg    <= next_isCfg;
      isRd     <= next_isRd;
      cfgSel   <= next_cfgSel;
      dataCnt  <= next_dataCnt;
      cfgData  <= next_cfgData;
      pageBuf  <= next_pageBuf;
      pageMask <= next_pageMask;
      cfgReg   <= next_cfgReg;
    end
  end

  // Program timer next value: loaded at launch, counts down to idle
  always_comb begin
    next_progCnt = progCnt;
    if (progStart) begin
      next_progCnt = `EEWP_CNT_W'(PROG_CYCLES);
    end else if (busy) begin
      next_progCnt = progCnt - `EEWP_CNT_W'(1);
    end
  end

  // Program timer register
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      progCnt <= '0;
    end else begin
      progCnt <= next_progCnt;
    end
  end

  // Array commit of the buffered page bytes at launch
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `EEWP_PAGE_BYTES; i++) begin
      if (memWe && pageMask[i]) begin
        mem[{ptr[7:3], 3'(i)}] <= pageBuf[i];
      end
    end
  end

  // Checks on the gating behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  sequence progRun;
    busy [*8];
  endsequence

  sequence ackDriven;
    ackPh && sdaOe;
  endsequence

  busy_nack_a:
    assert property ((state == S_DEV) && byteDone && busy |=> ackPh && !sdaOe)
    else $error("address acknowledged during program cycle");

  idle_ack_a:
    assert property ((state == S_DEV) && byteDone && !busy
                     && addr_match(shiftReg, `EEWP_TYPE_ARRAY) |=> ackDriven)
    else $error("address not acknowledged when idle");

  busy_ignore_a:
    assert property (busy && (state == S_DEV) && ackPh && sclFall |=> state == S_SKIP)
    else $error("access accepted during program cycle");

  wp_gate_a:
    assert property (stopEv && wrPending && !isCfg && pins.wp && !busy |=> !busy)
    else $error("program cycle started with inhibit pin high");

  cycle_hold_a:
    assert property (progStart |=> progRun)
    else $error("program cycle ended early");

  data_ack_a:
    assert property ((state == S_WDAT) && byteDone |=> ackDriven)
    else $error("data byte not acknowledged");

  prot_abort_a:
    assert property (stopEv && wrPending && !isCfg && protHit |-> !memWe ##1 !busy)
    else $error("write into protected range went ahead");

  lock_freeze_a:
    assert property (cfgReg.lock |=> cfgReg == $past(cfgReg))
    else $error("locked configuration changed");

  confirm_match_a:
    assert property (cfgReg != $past(cfgReg) |-> $past(confirmOk))
    else $error("configuration changed without valid confirm");

  cfg_read_a:
    assert property ((state == S_RDAT) && isCfg |-> txReg[7:4] == 4'h0)
    else $error("configuration read with nonzero upper nibble");

  enable_off_a:
    assert property (!cfgReg.en |-> !protHit)
    else $error("protection hit with enable clear");

endmodule

// >>> verif/eewp_host.sv
// Two-wire bus host model: drives the link clock and pulls the data line
`timescale 1ns/1ps
`include "eewp_defines.svh"
module eewp_host (
  // Clock and resolved data line
  input  wire logic clk,
  input  wire logic sdaLine,
  // Link clock and data pull-down enable
  output logic      scl,
  output logic      sdaOe
);
  // Bus idle: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaOe = 1'b0;
  end
  // Wait a number of core clock edges
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit slot; data moves only while the clock is low
  task automatic bitSlot(input logic b, output logic r);
    scl <= 1'b0;
    waitc(5);
    sdaOe <= !b;
    waitc(5);
    scl <= 1'b1;
    waitc(5);
    r = sdaLine;
    waitc(5);
  endtask
  // Start or Stop: data edge while the clock is high
  task automatic cond(input logic isStop);
    scl <= 1'b0;
    waitc(5);
    sdaOe <= isStop;
    waitc(5);
    scl <= 1'b1;
    waitc(10);
    sdaOe <= !isStop;
    waitc(10);
  endtask
  // Byte out, most significant bit first; returns the acknowledge
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitSlot(d[i], r);
    bitSlot(1'b1, r);
    ack = !r;
  endtask
  // Byte in; host answers with a nack to end the read
  task automatic recvByte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitSlot(1'b1, r);
      d[i] = r;
    end
    bitSlot(1'b1, r);
  endtask
  // Byte or two-byte write; ok when every byte was acknowledged
  task automatic wr(input logic [3:0] kind, input logic [7:0] adr, input logic [7:0] d0,
                    input logic [7:0] d1, input int n, output logic ok);
    logic a;
    cond(1'b0);
    sendByte({kind, `EEWP_HW_ADDR, 1'b0}, ok);
    sendByte(adr, a);
    ok = ok & a;
    sendByte(d0, a);
    ok = ok & a;
    if (n > 1) begin
      sendByte(d1, a);
      ok = ok & a;
    end
    cond(1'b1);
  endtask
  // Random read: dummy write of the word address, repeated Start, one byte
  task automatic rd(input logic [3:0] kind, input logic [7:0] adr,
                    output logic [7:0] d, output logic ok);
    logic a;
    cond(1'b0);
    sendByte({kind, `EEWP_HW_ADDR, 1'b0}, ok);
    sendByte(adr, a);
    ok = ok & a;
    cond(1'b0);
    sendByte({kind, `EEWP_HW_ADDR, 1'b1}, a);
    ok = ok & a;
    recvByte(d);
    cond(1'b1);
  endtask
  // Acknowledge poll: Start plus address byte with write direction
  task automatic poll(input logic [7:0] dev, output logic ack);
    cond(1'b0);
    sendByte(dev, ack);
    cond(1'b1);
  endtask
endmodule

// >>> verif/tb_eewp_top.sv
// Self-checking bench for the EEPROM write-gating core
`timescale 1ns/1ps
module tb_eewp_top;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] adr;
    logic       prot;
  } eewp_row_s;
  localparam int PROG = 300;
  localparam int LIMIT = 90000;
  logic      core_clk = 1'b0;
  logic      arst_n   = 1'b0;
  logic      wpIn     = 1'b0;
  logic      sdaOe, sdaOut, progBusy, scl, hostOe, ok, ack;
  int        errors   = 0;
  int        checks   = 0;
  int        cyc      = 0;
  // Open-drain line: device drives its output level when enabled, else pull-up
  wire logic sdaLine  = (sdaOe ? sdaOut : 1'b1) & !hostOe;
  // Configuration, target row, protected or not
  eewp_row_s rows [8] = '{'{8'h46, 8'hFF, 1'b0}, '{8'h48, 8'hBF, 1'b0},
                          '{8'h48, 8'hC0, 1'b1}, '{8'h4A, 8'h7F, 1'b0},
                          '{8'h4A, 8'h80, 1'b1}, '{8'h4C, 8'h3F, 1'b0},
                          '{8'h4C, 8'h40, 1'b1}, '{8'h4E, 8'h00, 1'b1}};
  // Faulty configuration writes: word address and data
  logic [7:0] badAdr [5] = '{8'hC0, 8'hC0, 8'hC0, 8'h80, 8'hFF};
  logic [7:0] badDat [5] = '{8'h0E, 8'h6E, 8'h4F, 8'h4E, 8'h4E};

  eewp_top #(.PROG_CYCLES(PROG)) eewp_top_i (
    .core_clk(core_clk), .arst_n(arst_n), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .wpIn(wpIn), .progBusy(progBusy));
  eewp_host eewp_host_i (.clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaOe(hostOe));

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      give_verdict();
    end
  end
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for the program cycle to end
  task automatic idle();
    int n;
    n = 0;
    while (progBusy !== 1'b0 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk(progBusy, 8'h00, "busy end");
  endtask
  // Reset held for 5 cycles, then settle time before the first frame
  task automatic doReset();
    arst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0] d;
    int         n;
    doReset();
    eewp_host_i.rd(4'hB, 8'hC0, d, ok);
    chk(d, 8'h00, "cfg reset");
    chk(ok, 8'h01, "cfg ack");
    $display("TEST reset done");
    // Known contents in every row while protection is off
    for (int i = 0; i < 8; i++) begin
      eewp_host_i.wr(4'hA, rows[i].adr, rows[i].adr ^ 8'h55, 8'h00, 1, ok);
      idle();
    end
    for (int i = 0; i < 8; i++) begin
      eewp_host_i.wr(4'hB, 8'hC0 | 8'(i), rows[i].cfg, 8'h00, 1, ok);
      idle();
      eewp_host_i.rd(4'hB, 8'hFF, d, ok);
      chk(d, rows[i].cfg & 8'h0F, "cfg read");
      eewp_host_i.wr(4'hA, rows[i].adr, ~rows[i].adr, 8'h00, 1, ok);
      chk(progBusy, {7'h0, !rows[i].prot}, "busy");
      chk(ok, 8'h01, "ack");
      idle();
      eewp_host_i.rd(4'hA, rows[i].adr, d, ok);
      chk(d, rows[i].prot ? rows[i].adr ^ 8'h55 : ~rows[i].adr, "array");
    end
    $display("TEST ranges done");
    eewp_host_i.wr(4'hB, 8'hC0, 8'h40, 8'h00, 1, ok);
    idle();
    // Access during the program cycle, then polling
    eewp_host_i.wr(4'hA, 8'h20, 8'h33, 8'h00, 1, ok);
    eewp_host_i.wr(4'hA, 8'h20, 8'h77, 8'h00, 1, ok);
    chk(ok, 8'h00, "busy nack");
    eewp_host_i.wr(4'hA, 8'h21, 8'h44, 8'h00, 1, ok);
    eewp_host_i.poll(8'hA0, ack);
    chk(ack, 8'h00, "poll busy");
    n = 0;
    while (ack !== 1'b1 && n < 5) begin
      eewp_host_i.poll(8'hA0, ack);
      n++;
    end
    chk(ack, 8'h01, "poll done");
    eewp_host_i.poll(8'hA2, ack);
    chk(ack, 8'h00, "wrong address");
    eewp_host_i.rd(4'hA, 8'h20, d, ok);
    chk(d, 8'h33, "ignored");
    $display("TEST busy done");
    // Inhibit pin
    wpIn <= 1'b1;
    eewp_host_i.wr(4'hA, 8'h20, 8'h99, 8'h00, 1, ok);
    chk(ok, 8'h01, "wp ack");
    chk(progBusy, 8'h00, "wp busy");
    eewp_host_i.poll(8'hA0, ack);
    chk(ack, 8'h01, "wp ready");
    eewp_host_i.rd(4'hA, 8'h20, d, ok);
    chk(d, 8'h33, "wp kept");
    wpIn <= 1'b0;
    eewp_host_i.wr(4'hA, 8'h20, 8'h99, 8'h5A, 2, ok);
    wpIn <= 1'b1;
    chk(progBusy, 8'h01, "wp late");
    idle();
    wpIn <= 1'b0;
    eewp_host_i.rd(4'hA, 8'h20, d, ok);
    chk(d, 8'h99, "wp late data");
    eewp_host_i.rd(4'hA, 8'h21, d, ok);
    chk(d, 8'h5A, "page second byte");
    $display("TEST inhibit done");
    // Malformed configuration writes leave the register alone
    for (int k = 0; k < 5; k++) begin
      eewp_host_i.wr(4'hB, badAdr[k], badDat[k], badDat[k], (k == 4) ? 2 : 1, ok);
      chk(progBusy, 8'h00, "bad busy");
      idle();
      eewp_host_i.rd(4'hB, 8'hC0, d, ok);
      chk(d, 8'h00, "bad cfg");
    end
    $display("TEST faults done");
    // Lock, then a refused change, then reset
    eewp_host_i.wr(4'hB, 8'hC0, 8'h6F, 8'h00, 1, ok);
    idle();
    eewp_host_i.wr(4'hB, 8'hC0, 8'h40, 8'h00, 1, ok);
    chk(progBusy, 8'h00, "locked busy");
    idle();
    eewp_host_i.rd(4'hB, 8'hC0, d, ok);
    chk(d, 8'h0F, "locked");
    doReset();
    eewp_host_i.rd(4'hB, 8'hC0, d, ok);
    chk(d, 8'h00, "cfg reset again");
    $display("TEST lock done");
    give_verdict();
  end
endmodule
